// file: core/sdrc_pkg.sv
// Shared constants and types for the sigma-delta result and mode control block
package sdrc_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int SDRC_NUM_CH = 3;
  localparam int SDRC_FILT_W = 24;
  localparam int SDRC_RES_W = 16;
  localparam int SDRC_BYTE_W = 8;
  localparam int SDRC_OSR_W = 2;
  localparam int SDRC_DLY_W = 2;
  // ----------------------------------------
  // Oversampling ratio codes and decimation counts
  // ----------------------------------------
  localparam logic [1:0] SDRC_OSR_256 = 2'h0;
  localparam logic [1:0] SDRC_OSR_128 = 2'h1;
  localparam logic [1:0] SDRC_OSR_64 = 2'h2;
  localparam logic [1:0] SDRC_OSR_32 = 2'h3;
  localparam logic [8:0] SDRC_DEC_256 = 9'h100;
  localparam logic [8:0] SDRC_DEC_128 = 9'h080;
  localparam logic [8:0] SDRC_DEC_64 = 9'h040;
  localparam logic [8:0] SDRC_DEC_32 = 9'h020;
  // ----------------------------------------
  // Format, delay and counter constants
  // ----------------------------------------
  localparam logic [23:0] SDRC_SIGN_FLIP = 24'h800000;
  localparam logic [1:0] SDRC_DLY_FOURTH = 2'h0;
  localparam logic [2:0] SDRC_DLY_BASE = 3'h4;
  localparam logic [8:0] SDRC_CNT_RESET = 9'h000;
  // ----------------------------------------
  // Channel state
  // ----------------------------------------
  typedef enum logic [1:0] {
    SDRC_ST_OFF = 2'b00,
    SDRC_ST_WAIT = 2'b01,
    SDRC_ST_RUN = 2'b10
  } sdrc_state_t;
endpackage : sdrc_pkg

// file: core/sdrc_frame_if.sv
// Frame timing handed from the frame timer to the channel logic
`timescale 1ns/1ns
interface sdrc_frame_if #(parameter int N = 3);
  logic [N-1:0] run;
  logic [N-1:0] restart;
  logic [N-1:0] done;
  modport timer (input run, input restart, output done);
  modport ctrl (output run, output restart, input done);
endinterface : sdrc_frame_if

// file: core/sdrc_frame_timer.sv
// Per-channel decimation counters producing the end-of-frame pulse
`timescale 1ns/1ns
module sdrc_frame_timer
  import sdrc_pkg::*;
#(
  parameter int N = SDRC_NUM_CH
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Modulator clock enable and ratio
  input wire logic i_mod_en,
  input wire logic [SDRC_OSR_W-1:0] i_osr,
  // Frame link
  sdrc_frame_if.timer frm
);
  logic [8:0] dec_len;
  logic [N-1:0][8:0] cnt;
  logic [N-1:0][8:0] next_cnt;
  logic [N-1:0] done;
  logic [N-1:0] next_done;

  // Decimation length from the ratio
  always_comb begin
    case (i_osr)
      SDRC_OSR_256: dec_len = SDRC_DEC_256;
      SDRC_OSR_128: dec_len = SDRC_DEC_128;
      SDRC_OSR_64: dec_len = SDRC_DEC_64;
      default: dec_len = SDRC_DEC_32;
    endcase
  end

  // Counters restart on request so members line up with their master
  always_comb begin
    for (int c = 0; c < N; c++) begin
      next_cnt[c] = cnt[c];
      next_done[c] = 1'b0;
      if (!frm.run[c] || frm.restart[c]) begin
        next_cnt[c] = SDRC_CNT_RESET;
      end else if (i_mod_en) begin
        // A ratio cut below the count mid-frame ends the frame at once instead of wrapping
        if (cnt[c] >= dec_len - 9'h001) begin
          next_cnt[c] = SDRC_CNT_RESET;
          next_done[c] = 1'b1;
        end else begin
          next_cnt[c] = cnt[c] + 9'h001;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= '0;
      done <= '0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end

  assign frm.done = done;
endmodule : sdrc_frame_timer

// file: core/sdrc_format.sv
// Result formatting and window selection for one read
`timescale 1ns/1ns
module sdrc_format
  import sdrc_pkg::*;
(
  // Latched filter word and settings
  input wire logic [SDRC_FILT_W-1:0] i_filt,
  input wire logic [SDRC_OSR_W-1:0] i_osr,
  input wire logic i_twos,
  input wire logic i_lsb_acc,
  input wire logic i_byte,
  // Read data
  output logic [SDRC_RES_W-1:0] o_data
);
  logic [SDRC_FILT_W-1:0] fmt;
  logic [SDRC_RES_W-1:0] high;
  logic [SDRC_RES_W-1:0] word;

  always_comb begin
    // Filter is two's complement; offset binary flips the sign bit
    fmt = i_twos ? i_filt : (i_filt ^ SDRC_SIGN_FLIP);
    // Top 16 bits; the low bit has no weight at the smallest ratio
    high = fmt[23:8];
    if (i_osr == SDRC_OSR_32) begin
      high[0] = 1'b0;
    end
    word = i_lsb_acc ? fmt[15:0] : high;
    o_data = i_byte ? {8'h00, fmt[7:0]} : word;
  end
endmodule : sdrc_format

// file: core/sdrc_top.sv
// Result path and conversion-mode control of a multichannel sigma-delta converter
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ns
module sdrc_top
  import sdrc_pkg::*;
#(
  parameter int N = SDRC_NUM_CH
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Modulator clock enable and filter stream
  input wire logic i_mod_en,
  input wire logic [N-1:0][SDRC_FILT_W-1:0] i_filt_out,
  // Common configuration
  input wire logic [SDRC_OSR_W-1:0] i_oversampling_ratio_select,
  input wire logic i_data_format_select,
  // Per-channel configuration
  input wire logic [N-1:0] i_single_conversion_select,
  input wire logic [N-1:0] i_group_with_next,
  input wire logic [N-1:0] i_low_bits_toggle,
  input wire logic [N-1:0][SDRC_DLY_W-1:0] i_interrupt_delay_select,
  // Software strobes on start bits, access bit and flags
  input wire logic [N-1:0] i_start_set,
  input wire logic [N-1:0] i_start_clr,
  input wire logic [N-1:0] i_lsb_acc_wr,
  input wire logic [N-1:0] i_lsb_acc_val,
  input wire logic [N-1:0] i_ready_clr,
  input wire logic [N-1:0] i_ovf_clr,
  // Result register read
  input wire logic i_rd,
  input wire logic [1:0] i_rd_ch,
  input wire logic i_rd_byte,
  // Status
  output logic [SDRC_RES_W-1:0] o_rd_data,
  output logic [N-1:0] o_start_conversion_bit,
  output logic [N-1:0] o_group_with_next,
  output logic [N-1:0] o_low_bits_access,
  output logic [N-1:0] o_result_ready_flag,
  output logic [N-1:0] o_result_overflow_flag,
  output logic [N-1:0] o_conv_req,
  output logic [N-1:0] o_chan_power
);
  // Read channel field is two bits wide, so at most four channels
  if (N < 1 || N > 4) begin : g_bad_n
    $error("sdrc_top: channel count must be 1 to 4");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  sdrc_frame_if #(.N(N)) frm ();
  sdrc_state_t st [N];
  sdrc_state_t next_st [N];
  logic [N-1:0] start;
  logic [N-1:0] next_start;
  logic [N-1:0] lsb_acc;
  logic [N-1:0] next_lsb_acc;
  logic [N-1:0] ready;
  logic [N-1:0] next_ready;
  logic [N-1:0] ovf;
  logic [N-1:0] next_ovf;
  logic [N-1:0] req;
  logic [N-1:0] next_req;
  logic [N-1:0][2:0] settle;
  logic [N-1:0][2:0] next_settle;
  logic [N-1:0][SDRC_FILT_W-1:0] latch;
  logic [N-1:0][SDRC_FILT_W-1:0] next_latch;
  logic [SDRC_RES_W-1:0] rd_data;
  logic [SDRC_RES_W-1:0] fmt_data;
  logic [N-1:0] grp_eff;
  logic [N-1:0][1:0] master;
  logic [N-1:0] is_master;
  logic [N-1:0] grouped;
  logic [N-1:0] rd_hit;
  logic [N-1:0] run;
  logic [N-1:0] restart;
  logic [N-1:0] done;
  logic [N-1:0] mset;
  logic [N-1:0] mclr;

  // ----------------------------------------
  // Group topology
  // ----------------------------------------
  // Top channel bit is dead; a master's own bit reads zero by definition
  always_comb begin
    grp_eff = i_group_with_next;
    grp_eff[N-1] = 1'b0;
  end

  // Each channel's master is the first channel at or above it with its bit clear
  generate
    for (genvar c = 0; c < N; c++) begin : g_master
      always_comb begin
        master[c] = 2'(c);
        for (int k = N - 1; k >= c; k--) begin
          if (k == c || !grp_eff[k]) begin
            master[c] = 2'(k);
          end
        end
        for (int k = c; k < N; k++) begin
          if (!grp_eff[k]) begin
            master[c] = 2'(k);
            break;
          end
        end
        grouped[c] = grp_eff[c] || (c > 0 && grp_eff[(c > 0) ? c - 1 : 0]);
        is_master[c] = grouped[c] && !grp_eff[c];
        rd_hit[c] = i_rd && (i_rd_ch == 2'(c));
      end
    end
  endgenerate

  // Master start strobes fan out to every member of its group
  always_comb begin
    for (int c = 0; c < N; c++) begin
      mset[c] = i_start_set[master[c]] && grouped[c] && master[c] != 2'(c);
      mclr[c] = i_start_clr[master[c]] && grouped[c] && master[c] != 2'(c);
    end
  end

  // ----------------------------------------
  // Channel control and result path
  // ----------------------------------------
  always_comb begin
    for (int c = 0; c < N; c++) begin
      next_st[c] = st[c];
      next_start[c] = start[c];
      next_ready[c] = ready[c];
      next_ovf[c] = ovf[c];
      next_req[c] = 1'b0;
      next_settle[c] = settle[c];
      next_latch[c] = latch[c];
      next_lsb_acc[c] = lsb_acc[c];
      // A waiting member is released on the master's frame edge, counting in step
      run[c] = (st[c] == SDRC_ST_RUN) || (st[c] == SDRC_ST_WAIT && done[master[c]]);
      restart[c] = (st[c] == SDRC_ST_WAIT) && !done[master[c]];
      // Start bit: set from software or master, clear wins for stop
      if (i_start_set[c] || mset[c]) begin
        next_start[c] = 1'b1;
      end
      if (i_start_clr[c] || mclr[c]) begin
        next_start[c] = 1'b0;
      end
      // Clears go first, so a result landing in the same cycle wins
      if (rd_hit[c] || i_ready_clr[c]) begin
        next_ready[c] = 1'b0;
      end
      if (i_ovf_clr[c]) begin
        next_ovf[c] = 1'b0;
      end
      case (st[c])
        SDRC_ST_OFF: begin
          if (next_start[c] && !start[c]) begin
            next_settle[c] = 3'h0;
            if (grouped[c] && !is_master[c] && start[master[c]]) begin
              next_st[c] = SDRC_ST_WAIT;
            end else begin
              next_st[c] = SDRC_ST_RUN;
            end
          end
        end
        SDRC_ST_WAIT: begin
          if (!next_start[c]) begin
            next_st[c] = SDRC_ST_OFF;
          end else if (done[master[c]]) begin
            next_st[c] = SDRC_ST_RUN;
          end
        end
        SDRC_ST_RUN: begin
          if (!next_start[c]) begin
            next_st[c] = SDRC_ST_OFF;
          end else if (done[c]) begin
            next_latch[c] = i_filt_out[c];
            next_ovf[c] = next_ovf[c] | ready[c];
            next_ready[c] = 1'b1;
            if (settle[c] < SDRC_DLY_BASE - {1'b0, i_interrupt_delay_select[c]}) begin
              next_settle[c] = settle[c] + 3'h1;
            end
            if (settle[c] + 3'h1 >= SDRC_DLY_BASE - {1'b0, i_interrupt_delay_select[c]}) begin
              next_req[c] = 1'b1;
            end
            if (i_single_conversion_select[c]) begin
              next_start[c] = 1'b0;
              next_st[c] = SDRC_ST_OFF;
            end
          end
        end
        default: next_st[c] = SDRC_ST_OFF;
      endcase
      // Toggle acts on reads only, so changing it alone has no effect
      if (i_lsb_acc_wr[c]) begin
        next_lsb_acc[c] = i_lsb_acc_val[c];
      end else if (rd_hit[c] && i_low_bits_toggle[c]) begin
        next_lsb_acc[c] = ~lsb_acc[c];
      end
    end
  end

  // Read port picks the addressed channel's latched word
  sdrc_format u_format (
    .i_filt(latch[int'(i_rd_ch) < N ? i_rd_ch : 2'h0]),
    .i_osr(i_oversampling_ratio_select),
    .i_twos(i_data_format_select),
    .i_lsb_acc(lsb_acc[int'(i_rd_ch) < N ? i_rd_ch : 2'h0]),
    .i_byte(i_rd_byte),
    .o_data(fmt_data)
  );

  // Read data is held between reads
  always_comb begin
    rd_data = (i_rd && int'(i_rd_ch) < N) ? fmt_data : o_rd_data;
  end

  // ----------------------------------------
  // Frame timer
  // ----------------------------------------
  assign frm.run = run;
  assign frm.restart = restart;
  assign done = frm.done;

  sdrc_frame_timer #(.N(N)) u_timer (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_mod_en(i_mod_en),
    .i_osr(i_oversampling_ratio_select),
    .frm(frm)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int c = 0; c < N; c++) begin
        st[c] <= SDRC_ST_OFF;
      end
      start <= '0;
      lsb_acc <= '0;
      ready <= '0;
      ovf <= '0;
      req <= '0;
      settle <= '0;
      latch <= '0;
      o_rd_data <= '0;
      o_group_with_next <= '0;
      o_chan_power <= '0;
    end else begin
      st <= next_st;
      start <= next_start;
      lsb_acc <= next_lsb_acc;
      ready <= next_ready;
      ovf <= next_ovf;
      req <= next_req;
      settle <= next_settle;
      latch <= next_latch;
      o_rd_data <= rd_data;
      o_group_with_next <= grp_eff;
      for (int c = 0; c < N; c++) begin
        o_chan_power[c] <= (next_st[c] != SDRC_ST_OFF);
      end
    end
  end

  // Status outputs straight from flip-flops
  assign o_start_conversion_bit = start;
  assign o_low_bits_access = lsb_acc;
  assign o_result_ready_flag = ready;
  assign o_result_overflow_flag = ovf;
  assign o_conv_req = req;
endmodule : sdrc_top

// file: verification/sdrc_top_asserts.sv
// Concurrent checks on the ports of the result and mode control block
`timescale 1ns/1ns
module sdrc_top_asserts
  import sdrc_pkg::*;
#(
  parameter int N = SDRC_NUM_CH
) (
  // Clock, reset, software strobes, per-channel mode bits and read
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [N-1:0] i_start_set,
  input wire logic [N-1:0] i_start_clr,
  input wire logic [N-1:0] i_single_conversion_select,
  input wire logic [N-1:0] i_low_bits_toggle,
  input wire logic [N-1:0] i_lsb_acc_wr,
  input wire logic i_rd,
  input wire logic [1:0] i_rd_ch,
  // Observed outputs
  input wire logic [SDRC_RES_W-1:0] o_rd_data,
  input wire logic [N-1:0] o_start_conversion_bit,
  input wire logic [N-1:0] o_group_with_next,
  input wire logic [N-1:0] o_low_bits_access,
  input wire logic [N-1:0] o_result_ready_flag,
  input wire logic [N-1:0] o_result_overflow_flag,
  input wire logic [N-1:0] o_conv_req,
  input wire logic [N-1:0] o_chan_power
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  a_clr_stops: assert property (i_start_clr[0] |=>
    !o_start_conversion_bit[0] && !o_chan_power[0]) else $error("clear left channel running");
  a_master_sets: assert property (i_start_set[1] && !i_start_clr[1] && !i_start_clr[0]
    && o_group_with_next[0] && !o_group_with_next[1] |=> o_start_conversion_bit[0])
    else $error("master start not passed on");
  a_top_grp_low: assert property (o_group_with_next[N-1] == 1'h0)
    else $error("top group bit set");
  a_ovf_cause: assert property ($rose(o_result_overflow_flag[0]) |->
    $past(o_result_ready_flag[0])) else $error("overflow without unread result");
  a_rdy_powered: assert property ($rose(o_result_ready_flag[0]) |->
    $past(o_chan_power[0])) else $error("result while powered down");
  a_single_done: assert property ($rose(o_result_ready_flag[0])
    && i_single_conversion_select[0] && !o_group_with_next[0] |-> !o_start_conversion_bit[0])
    else $error("single conversion kept start");
  a_acc_toggle: assert property (i_rd && i_rd_ch == 2'h1 && i_low_bits_toggle[1]
    && !i_lsb_acc_wr[1] |=> o_low_bits_access[1] != $past(o_low_bits_access[1]))
    else $error("access bit did not toggle");
  a_acc_hold: assert property (!(i_rd && i_rd_ch == 2'h1) && !i_lsb_acc_wr[1] |=>
    $stable(o_low_bits_access[1])) else $error("access bit moved without access");
  a_data_hold: assert property (!i_rd |=> $stable(o_rd_data))
    else $error("read data moved without read");
  a_req_pulse: assert property (o_conv_req[2] |->
    o_result_ready_flag[2] ##1 !o_conv_req[2]) else $error("bad request pulse");
  // Main scenarios reached
  c_req: cover property (o_conv_req[2]);
  c_ovf: cover property ($rose(o_result_overflow_flag[0]));
  c_tog: cover property (i_rd && i_low_bits_toggle[1]);
endmodule : sdrc_top_asserts

bind sdrc_top sdrc_top_asserts #(.N(N)) u_chk (.i_core_clk, .i_rst, .i_start_set,
  .i_start_clr, .i_single_conversion_select, .i_low_bits_toggle, .i_lsb_acc_wr, .i_rd,
  .i_rd_ch, .o_rd_data, .o_start_conversion_bit, .o_group_with_next, .o_low_bits_access,
  .o_result_ready_flag, .o_result_overflow_flag, .o_conv_req, .o_chan_power);

// file: verification/tb.sv
// Self-checking bench for the sigma-delta result and mode control block
`timescale 1ns/1ns
module tb;
  import sdrc_pkg::*;
  localparam int N = SDRC_NUM_CH;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic i_core_clk = 1'h0;
  logic i_rst = 1'h1;
  logic mod_en = 1'h0;
  logic [N-1:0][SDRC_FILT_W-1:0] filt = '0;
  logic [1:0] osr = SDRC_OSR_256;
  logic df = 1'h0;
  logic [N-1:0][1:0] dly = '0;
  logic [N-1:0] sngl = '0, grp = '0, tog = '0, aval = '0;
  logic [N-1:0] sset = '0, sclr = '0, awr = '0, rclr = '0, oclr = '0;
  logic rd = 1'h0;
  logic [1:0] rd_ch = 2'h0;
  logic rd_byte = 1'h0;
  logic pend = 1'h0;
  logic [15:0] rd_data;
  logic [N-1:0] start, grp_o, acc, rdy, ovf, req, pwr;
  logic [15:0] exp_q[$];
  logic [23:0] f;
  logic [23:0] fs[3] = '{24'h7FFFFF, 24'h000000, 24'h800000};
  logic [15:0] fx[6] = '{16'hFFFF, 16'h8000, 16'h0000, 16'h7FFF, 16'h0000, 16'h8000};
  int err_count = 0;
  int comparisons = 0;
  int req_cnt = 0;
  int base;
  int cyc = 0;
  // Clock, and a modulator tick every second cycle
  always #10 i_core_clk = ~i_core_clk;
  always @(negedge i_core_clk) mod_en <= ~mod_en;
  sdrc_top #(.N(N)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_mod_en(mod_en),
    .i_filt_out(filt), .i_oversampling_ratio_select(osr), .i_data_format_select(df),
    .i_single_conversion_select(sngl), .i_group_with_next(grp), .i_low_bits_toggle(tog),
    .i_interrupt_delay_select(dly), .i_start_set(sset), .i_start_clr(sclr),
    .i_lsb_acc_wr(awr), .i_lsb_acc_val(aval), .i_ready_clr(rclr), .i_ovf_clr(oclr),
    .i_rd(rd), .i_rd_ch(rd_ch), .i_rd_byte(rd_byte), .o_rd_data(rd_data),
    .o_start_conversion_bit(start), .o_group_with_next(grp_o), .o_low_bits_access(acc),
    .o_result_ready_flag(rdy), .o_result_overflow_flag(ovf), .o_conv_req(req),
    .o_chan_power(pwr));
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : check
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  // Read data lands one cycle after the read; compared at the next falling edge
  always @(posedge i_core_clk) pend <= rd && rd_ch < 2'(N);
  always @(negedge i_core_clk) begin
    req_cnt <= req_cnt + int'(req[2] === 1'h1);
    cyc <= cyc + 1;
    if (pend) check(rd_data, exp_q.pop_front());
  end
  // Expected word: sign flip for offset binary, lowest bit dropped at ratio 32
  function automatic logic [15:0] word(input logic [23:0] v, input logic a);
    logic [23:0] g;
    g = df ? v : v ^ 24'h800000;
    if (a) return g[15:0];
    if (osr == SDRC_OSR_32) return {g[23:9], 1'h0};
    return g[23:8];
  endfunction : word
  // ----------------------------------------
  // Drivers, all acting at the falling edge
  // ----------------------------------------
  task automatic strobe(ref logic [N-1:0] s, input logic [N-1:0] m);
    s = m;
    @(negedge i_core_clk);
    s = '0;
  endtask : strobe
  task automatic rd_word(input int c, input logic b, input logic [15:0] w);
    rd = 1'h1;
    rd_ch = 2'(c);
    rd_byte = b;
    exp_q.push_back(w);
    @(negedge i_core_clk);
  endtask : rd_word
  // Waits for any masked flag, then demands all of them in the same cycle
  task automatic wait_rdy(input logic [N-1:0] m);
    int n;
    n = 0;
    while ((rdy & m) === '0 && n < 1200) begin
      @(negedge i_core_clk);
      n++;
    end
    check(rdy & m, m);
  endtask : wait_rdy
  // Input is changed two cycles ahead so a result racing the clear is already new
  task automatic fresh(input int c, input logic [23:0] v);
    filt[c] = v;
    repeat (2) @(negedge i_core_clk);
    strobe(rclr, N'(1 << c));
    wait_rdy(N'(1 << c));
  endtask : fresh
  initial begin
    #1000000;
    err_count++;
    close_out();
  end
  initial begin
    void'($urandom(32'hCD77D056));
    repeat (16) @(negedge i_core_clk);
    i_rst = 1'h0;
    @(negedge i_core_clk);
    // Format table, then random words at ratio 32
    strobe(sset, N'(1));
    for (int k = 0; k < 10; k++) begin
      df = (k > 2);
      osr = (k > 5) ? SDRC_OSR_32 : SDRC_OSR_256;
      f = (k > 5) ? 24'($urandom) : fs[k % 3];
      fresh(0, f);
      rd_word(0, 1'h0, (k > 5) ? word(f, 1'h0) : fx[k]);
      rd = 1'h0;
      check(rdy[0], 1'h0);
    end
    // Continuous run left unread, then stopped
    repeat (200) @(negedge i_core_clk);
    check(start[0], 1'h1);
    check(ovf[0], 1'h1);
    strobe(sclr, N'(1));
    check({start[0], pwr[0]}, 2'h0);
    // Cleared only once stopped, so no new result can win over the clear
    strobe(oclr, N'(1));
    check(ovf[0], 1'h0);
    // Single conversion runs exactly once
    sngl[0] = 1'h1;
    strobe(sset, N'(1));
    fresh(0, 24'($urandom));
    @(negedge i_core_clk);
    check({start[0], pwr[0]}, 2'h0);
    strobe(rclr, N'(1));
    repeat (150) @(negedge i_core_clk);
    check(rdy[0], 1'h0);
    // Every delay code: requests start at result 4 minus the code
    for (int d = 0; d < 4; d++) begin
      dly[2] = 2'(d);
      base = req_cnt;
      strobe(sset, N'(4));
      for (int k = 1; k < 5; k++) begin
        fresh(2, 24'($urandom));
        @(negedge i_core_clk);
        check(16'(req_cnt - base), 16'((k > 3 - d) ? k - 3 + d : 0));
      end
      strobe(sclr, N'(4));
    end
    // Each ratio: results of a running channel come one frame of ticks apart
    for (int r = 0; r < 4; r++) begin
      osr = 2'(r);
      strobe(sset, N'(4));
      fresh(2, 24'($urandom));
      base = cyc;
      fresh(2, 24'($urandom));
      check(16'(cyc - base), 16'(2 * (int'(SDRC_DEC_256) >> r)));
      strobe(sclr, N'(4));
    end
    // Three toggled reads, the last a byte read, of one latched word, input moved meanwhile
    osr = SDRC_OSR_256;
    tog[1] = 1'h1;
    strobe(sset, N'(2));
    f = 24'($urandom);
    fresh(1, f);
    filt[1] = ~f;
    rd_word(1, 1'h0, word(f, 1'h0));
    rd_word(1, 1'h0, word(f, 1'h1));
    rd_word(1, 1'h1, {8'h00, f[7:0]});
    rd = 1'h0;
    tog[1] = 1'h0;
    repeat (3) @(negedge i_core_clk);
    check(acc[1], 1'h1);
    rd_word(1, 1'h0, word(f, 1'h1));
    rd = 1'h0;
    strobe(awr, N'(2));
    check(acc[1], 1'h0);
    @(negedge i_core_clk);
    aval[1] = 1'h1;
    strobe(awr, N'(2));
    check(acc[1], 1'h1);
    strobe(sclr, N'(2));
    // Group: channel 0 joins master channel 1
    osr = SDRC_OSR_32;
    grp = N'(1);
    strobe(sset, N'(2));
    check(grp_o, N'(1));
    check(start[1:0], 2'h3);
    strobe(rclr, N'(3));
    wait_rdy(N'(3));
    @(negedge i_core_clk);
    check(start[1:0], 2'h2);
    sngl[0] = 1'h0;
    strobe(sset, N'(1));
    strobe(rclr, N'(3));
    wait_rdy(N'(2));
    check(rdy[0], 1'h0);
    strobe(rclr, N'(3));
    wait_rdy(N'(3));
    repeat (10) @(negedge i_core_clk);
    strobe(sclr, N'(2));
    check({start[1:0], pwr[1:0]}, 4'h0);
    grp = '1;
    repeat (2) @(negedge i_core_clk);
    check(grp_o, N'(3));
    close_out();
  end
endmodule : tb
